// File: logic/lane_mapper_consts.vh
// Constants for the transport-layer lane mapper
//
// Overview of operation
// - Mode 24: I0,I1 link A; Q0,Q1 link B
// - Modes 48,62,65,70 copy mode 24 layout
// - Mode 25: eight lanes, flag shared per pair
// - Mode 52 copies mode 25 layout
// - Mode 26: four lanes each, own flags
// - Modes 54,63 copy mode 26 layout
// - Mode 27: eight lanes each, own flags
// - Mode 32: even samples A, odd samples B
// - Contiguous 12-bit packing across three lanes
// - Mode 33: channel A/B packed per link
// - Mode 34: one octet, S0 S2 A, S1 S3 B
// - Mode 35: one octet, A and B channels
// - Mode 37: dual channel I/Q, two lanes
// - Mode 38: I0 link A, Q0 link B
// - Down-converted lane word: 15-bit value plus flag
// - Most significant bit sent first
// - Bypass samples are 12-bit offset binary
// - Lowest lanes used, upper lanes powered down
`ifndef LANE_MAPPER_CONSTS_VH
`define LANE_MAPPER_CONSTS_VH

`define MODE_W        7
`define LANE_W        16
`define LANES         8
`define DDC_W         15
`define RAW_W         12
`define OCTET_W       8

`define MODE_24       7'h18
`define MODE_48       7'h30
`define MODE_62       7'h3e
`define MODE_65       7'h41
`define MODE_70       7'h46
`define MODE_25       7'h19
`define MODE_52       7'h34
`define MODE_26       7'h1a
`define MODE_54       7'h36
`define MODE_63       7'h3f
`define MODE_27       7'h1b
`define MODE_32       7'h20
`define MODE_33       7'h21
`define MODE_34       7'h22
`define MODE_35       7'h23
`define MODE_37       7'h25
`define MODE_38       7'h26

`define LANES_2       4'h2
`define LANES_3       4'h3
`define LANES_4       4'h4
`define LANES_8       4'h8
`define LANES_1       4'h1
`define LANES_0       4'h0

`define LANE_RESET    16'h0000

`endif

// File: logic/pack12_lanes.v
// Packs four 12-bit samples into three 16-bit lane words
`timescale 1ns/1ps
`default_nettype none
`include "lane_mapper_consts.vh"

module pack12_lanes (
   input  wire [11:0] samp_a,   // First sample
   input  wire [11:0] samp_b,   // Second sample
   input  wire [11:0] samp_c,   // Third sample
   input  wire [11:0] samp_d,   // Fourth sample
   output wire [15:0] lane0,    // Lane word 0
   output wire [15:0] lane1,    // Lane word 1
   output wire [15:0] lane2     // Lane word 2
);

   // Bit 15 of each word goes out first on the lane
   assign lane0 = {samp_a[11:0], samp_b[11:8]};
   assign lane1 = {samp_b[7:0],  samp_c[11:4]};
   assign lane2 = {samp_c[3:0],  samp_d[11:0]};

endmodule // pack12_lanes
`default_nettype wire

// File: logic/jesd_transport_lane_mapper.v
// Transport-layer mapper placing samples into per-lane frame words
`timescale 1ns/1ps
`default_nettype none
`include "lane_mapper_consts.vh"

module jesd_transport_lane_mapper #(
   parameter LANES = 8                           // Lanes per link
) (
   input  wire         clk,                      // 100 MHz frame clock
   input  wire         rst_b,                    // Async reset, low
   input  wire [6:0]   transport_mode_code,      // Programmed mode
   input  wire         frame_in_valid,           // New frame of samples
   input  wire [119:0] ddc_inphase,              // I[0..7], 15 bits each
   input  wire [119:0] ddc_quadrature,           // Q[0..7], 15 bits each
   input  wire [7:0]   overrange_flag_inphase,   // Flags for I words
   input  wire [7:0]   overrange_flag_quadrature,// Flags for Q words
   input  wire [14:0]  chan_a_inphase,           // Dual channel A I
   input  wire [14:0]  chan_a_quadrature,        // Dual channel A Q
   input  wire [14:0]  chan_b_inphase,           // Dual channel B I
   input  wire [14:0]  chan_b_quadrature,        // Dual channel B Q
   input  wire         overrange_flag_chan_a_inphase,    // A I flag
   input  wire         overrange_flag_chan_a_quadrature, // A Q flag
   input  wire         overrange_flag_chan_b_inphase,    // B I flag
   input  wire         overrange_flag_chan_b_quadrature, // B Q flag
   input  wire [95:0]  raw_sample,               // Eight 12-bit samples
   output wire [15:0]  link_a_lane0,             // Link A lane 0 word
   output wire [15:0]  link_a_lane1,             // Link A lane 1 word
   output wire [15:0]  link_a_lane2,             // Link A lane 2 word
   output wire [15:0]  link_a_lane3,             // Link A lane 3 word
   output wire [15:0]  link_a_lane4,             // Link A lane 4 word
   output wire [15:0]  link_a_lane5,             // Link A lane 5 word
   output wire [15:0]  link_a_lane6,             // Link A lane 6 word
   output wire [15:0]  link_a_lane7,             // Link A lane 7 word
   output wire [15:0]  link_b_lane0,             // Link B lane 0 word
   output wire [15:0]  link_b_lane1,             // Link B lane 1 word
   output wire [15:0]  link_b_lane2,             // Link B lane 2 word
   output wire [15:0]  link_b_lane3,             // Link B lane 3 word
   output wire [15:0]  link_b_lane4,             // Link B lane 4 word
   output wire [15:0]  link_b_lane5,             // Link B lane 5 word
   output wire [15:0]  link_b_lane6,             // Link B lane 6 word
   output wire [15:0]  link_b_lane7,             // Link B lane 7 word
   output wire [7:0]   lane_enable_a,            // Link A lanes powered
   output wire [7:0]   lane_enable_b,            // Link B lanes powered
   output wire         frame_out_valid,          // Frame words updated
   output wire         mode_supported            // Last mode was known
);

   ////////////////////////////////////////////////////////////////////////
   // Down-converted word: value in 15:1, overrange in bit 0

   function [15:0] ddc_word;
      input [14:0] value;
      input        flag;
      begin
         ddc_word = {value, flag};
      end
   endfunction

   // Bypass octet modes use the top eight bits, sent first
   function [15:0] octet_word;
      input [11:0] value;
      begin
         octet_word = {value[11:4], 8'h00};
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // 12-bit packing, one packer per link

   wire        pack_dual;
   wire [11:0] pa_0;
   wire [11:0] pa_1;
   wire [11:0] pa_2;
   wire [11:0] pa_3;
   wire [11:0] pb_0;
   wire [11:0] pb_1;
   wire [11:0] pb_2;
   wire [11:0] pb_3;
   wire [15:0] pack_a0;
   wire [15:0] pack_a1;
   wire [15:0] pack_a2;
   wire [15:0] pack_b0;
   wire [15:0] pack_b1;
   wire [15:0] pack_b2;

   assign pack_dual = (transport_mode_code == `MODE_33);
   // Single channel splits even and odd samples over the links
   assign pa_0 = pack_dual ? raw_sample[11:0]  : raw_sample[11:0];
   assign pa_1 = pack_dual ? raw_sample[23:12] : raw_sample[35:24];
   assign pa_2 = pack_dual ? raw_sample[35:24] : raw_sample[59:48];
   assign pa_3 = pack_dual ? raw_sample[47:36] : raw_sample[83:72];
   assign pb_0 = pack_dual ? raw_sample[59:48] : raw_sample[23:12];
   assign pb_1 = pack_dual ? raw_sample[71:60] : raw_sample[47:36];
   assign pb_2 = pack_dual ? raw_sample[83:72] : raw_sample[71:60];
   assign pb_3 = pack_dual ? raw_sample[95:84] : raw_sample[95:84];

   pack12_lanes u_pack_a (
      .samp_a (pa_0),
      .samp_b (pa_1),
      .samp_c (pa_2),
      .samp_d (pa_3),
      .lane0  (pack_a0),
      .lane1  (pack_a1),
      .lane2  (pack_a2)
   );

   pack12_lanes u_pack_b (
      .samp_a (pb_0),
      .samp_b (pb_1),
      .samp_c (pb_2),
      .samp_d (pb_3),
      .lane0  (pack_b0),
      .lane1  (pack_b1),
      .lane2  (pack_b2)
   );

   ////////////////////////////////////////////////////////////////////////
   // Layout selection from the mode code

   reg [127:0] next_lane_a;
   reg [127:0] next_lane_b;
   reg [3:0]   next_lanes;
   reg [3:0]   ddc_lanes;
   reg         ddc_shared;
   reg         next_supported;
   reg [7:0]   next_enable;
   integer     k;

   always @* begin
      next_lane_a    = 128'h0;
      next_lane_b    = 128'h0;
      next_lanes     = `LANES_0;
      ddc_lanes      = `LANES_0;
      ddc_shared     = 1'b0;
      next_supported = 1'b1;
      next_enable    = 8'h00;
      case (transport_mode_code)
         `MODE_24, `MODE_48, `MODE_62, `MODE_65, `MODE_70: begin
            ddc_lanes = `LANES_2;
         end
         `MODE_25, `MODE_52: begin
            ddc_lanes  = `LANES_8;
            ddc_shared = 1'b1;
         end
         `MODE_26, `MODE_54, `MODE_63: begin
            ddc_lanes = `LANES_4;
         end
         `MODE_27: begin
            ddc_lanes = `LANES_8;
         end
         `MODE_38: begin
            ddc_lanes = `LANES_1;
         end
         `MODE_37: begin
            next_lanes = `LANES_2;
            next_lane_a[15:0]  = ddc_word(chan_a_inphase,
               overrange_flag_chan_a_inphase);
            next_lane_a[31:16] = ddc_word(chan_a_quadrature,
               overrange_flag_chan_a_quadrature);
            next_lane_b[15:0]  = ddc_word(chan_b_inphase,
               overrange_flag_chan_b_inphase);
            next_lane_b[31:16] = ddc_word(chan_b_quadrature,
               overrange_flag_chan_b_quadrature);
         end
         `MODE_32, `MODE_33: begin
            // Offset binary codes pass through untouched
            next_lanes = `LANES_3;
            next_lane_a[47:0] = {pack_a2, pack_a1, pack_a0};
            next_lane_b[47:0] = {pack_b2, pack_b1, pack_b0};
         end
         `MODE_34: begin
            next_lanes = `LANES_2;
            next_lane_a[15:0]  = octet_word(raw_sample[11:0]);
            next_lane_a[31:16] = octet_word(raw_sample[35:24]);
            next_lane_b[15:0]  = octet_word(raw_sample[23:12]);
            next_lane_b[31:16] = octet_word(raw_sample[47:36]);
         end
         `MODE_35: begin
            next_lanes = `LANES_2;
            next_lane_a[15:0]  = octet_word(raw_sample[11:0]);
            next_lane_a[31:16] = octet_word(raw_sample[23:12]);
            next_lane_b[15:0]  = octet_word(raw_sample[59:48]);
            next_lane_b[31:16] = octet_word(raw_sample[71:60]);
         end
         default: begin
            // Unknown codes drive no lanes rather than a guessed layout
            next_supported = 1'b0;
         end
      endcase
      if (ddc_lanes != `LANES_0) begin
         next_lanes = ddc_lanes;
      end
      // Single-channel down-converted layouts share one loop
      for (k = 0; k < 8; k = k + 1) begin
         if (k < ddc_lanes) begin
            if (ddc_shared) begin
               next_lane_a[k*16 +: 16] = ddc_word(ddc_inphase[k*15 +: 15],
                  overrange_flag_inphase[k/2]);
               next_lane_b[k*16 +: 16] = ddc_word(
                  ddc_quadrature[k*15 +: 15],
                  overrange_flag_quadrature[k/2]);
            end else begin
               next_lane_a[k*16 +: 16] = ddc_word(ddc_inphase[k*15 +: 15],
                  overrange_flag_inphase[k]);
               next_lane_b[k*16 +: 16] = ddc_word(
                  ddc_quadrature[k*15 +: 15],
                  overrange_flag_quadrature[k]);
            end
         end
         if (k < next_lanes) begin
            next_enable[k] = 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Frame registers, one layout captured per frame

   reg [127:0] lane_a;
   reg [127:0] lane_b;
   reg [7:0]   enable_a;
   reg [7:0]   enable_b;
   reg         out_valid;
   reg         supported;

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         lane_a    <= 128'h0;
         lane_b    <= 128'h0;
         enable_a  <= 8'h00;
         enable_b  <= 8'h00;
         out_valid <= 1'b0;
         supported <= 1'b0;
      end else begin
         out_valid <= frame_in_valid;
         if (frame_in_valid) begin
            // Mode is read only here, so a change lands on a frame edge
            lane_a    <= next_lane_a;
            lane_b    <= next_lane_b;
            enable_a  <= next_enable;
            enable_b  <= next_enable;
            supported <= next_supported;
         end
      end
   end

   assign link_a_lane0    = lane_a[15:0];
   assign link_a_lane1    = lane_a[31:16];
   assign link_a_lane2    = lane_a[47:32];
   assign link_a_lane3    = lane_a[63:48];
   assign link_a_lane4    = lane_a[79:64];
   assign link_a_lane5    = lane_a[95:80];
   assign link_a_lane6    = lane_a[111:96];
   assign link_a_lane7    = lane_a[127:112];
   assign link_b_lane0    = lane_b[15:0];
   assign link_b_lane1    = lane_b[31:16];
   assign link_b_lane2    = lane_b[47:32];
   assign link_b_lane3    = lane_b[63:48];
   assign link_b_lane4    = lane_b[79:64];
   assign link_b_lane5    = lane_b[95:80];
   assign link_b_lane6    = lane_b[111:96];
   assign link_b_lane7    = lane_b[127:112];
   assign lane_enable_a   = enable_a;
   assign lane_enable_b   = enable_b;
   assign frame_out_valid = out_valid;
   assign mode_supported  = supported;

endmodule // jesd_transport_lane_mapper
`default_nettype wire

// File: verification/jesd_lane_receiver.sv
// Far-side receiver model that captures each frame off the lanes
`timescale 1ns/1ps
`default_nettype none
module jesd_lane_receiver (
   input  wire logic         clk,       // Frame clock
   input  wire logic         rst_b,     // Async reset, low
   input  wire logic         frame_vld, // Frame words updated
   input  wire logic [127:0] lanes_a,   // Link A lanes, lane k at 16k
   input  wire logic [127:0] lanes_b,   // Link B lanes
   input  wire logic [7:0]   enable,    // Lanes powered
   input  wire logic         supported, // Mode known
   output logic              rx_valid,  // Captured frame ready
   output logic      [127:0] rx_a,      // Captured link A
   output logic      [127:0] rx_b,      // Captured link B
   output logic      [7:0]   rx_en,     // Captured enables
   output logic              rx_sup,    // Captured mode flag
   output logic              rx_gap     // Enabled lanes not lowest
);
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         {rx_valid, rx_a, rx_b, rx_en, rx_sup, rx_gap} <= '0;
      end else begin
         rx_valid <= frame_vld;
         if (frame_vld) begin
            {rx_a, rx_b, rx_en, rx_sup} <= {lanes_a, lanes_b, enable, supported};
            // Only wired to the lowest lanes, so a hole is a lost lane
            rx_gap <= |((enable + 8'h01) & enable);
         end
      end
   end
endmodule // jesd_lane_receiver
`default_nettype wire

// File: verification/lane_mapper_asserts.sv
// Port-level checker for the lane mapper
`timescale 1ns/1ps
`default_nettype none
`include "lane_mapper_consts.vh"
module lane_mapper_checker (
   input wire logic         clk,                    // Clock
   input wire logic         rst_b,                  // Reset, low
   input wire logic [6:0]   transport_mode_code,    // Mode
   input wire logic         frame_in_valid,         // Frame taken
   input wire logic [119:0] ddc_inphase,            // I words
   input wire logic [7:0]   overrange_flag_inphase, // I flags
   input wire logic [95:0]  raw_sample,             // Raw samples
   input wire logic [15:0]  link_a_lane0,           // Lane A0
   input wire logic [15:0]  link_a_lane1,           // Lane A1
   input wire logic [15:0]  link_a_lane7,           // Lane A7
   input wire logic [7:0]   lane_enable_a,          // Enables A
   input wire logic [7:0]   lane_enable_b,          // Enables B
   input wire logic         frame_out_valid,        // Frame out
   input wire logic         mode_supported          // Mode known
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   wire logic f = frame_in_valid;
   wire logic [6:0] m = transport_mode_code;
   a_out_latency: assert property (f |=> frame_out_valid)
      else $error("frame not answered next cycle");
   a_out_pulse: assert property (!f |=> !frame_out_valid)
      else $error("frame pulse without a taken frame");
   a_hold_idle: assert property (!f |=> $stable(link_a_lane0) && $stable(lane_enable_a))
      else $error("lane output moved between frames");
   a_mode24_word: assert property (f && m == `MODE_24 |=> link_a_lane0 == {$past(ddc_inphase[14:0]), $past(overrange_flag_inphase[0])})
      else $error("mode 24 lane word wrong");
   a_mode25_shared: assert property (f && m == `MODE_25 |=> link_a_lane1 == {$past(ddc_inphase[29:15]), $past(overrange_flag_inphase[0])})
      else $error("mode 25 shared flag wrong");
   a_mode27_top: assert property (f && m == `MODE_27 |=> link_a_lane7 == {$past(ddc_inphase[119:105]), $past(overrange_flag_inphase[7])})
      else $error("mode 27 top lane wrong");
   a_pack12_first: assert property (f && m == `MODE_32 |=> link_a_lane0 == {$past(raw_sample[11:0]), $past(raw_sample[35:32])})
      else $error("12-bit packing lane 0 wrong");
   a_octet_msb: assert property (f && m == `MODE_34 |=> link_a_lane1 == {$past(raw_sample[35:28]), 8'h00})
      else $error("mode 34 octet wrong");
   a_links_match: assert property (frame_out_valid |-> lane_enable_a == lane_enable_b)
      else $error("link enables differ");
   a_unknown_zero: assert property (frame_out_valid && !mode_supported |-> lane_enable_a == 8'h00 && link_a_lane0 == 16'h0000)
      else $error("unknown mode left lanes on");
   a_mode38_lanes: assert property (f && m == `MODE_38 |=> lane_enable_a == 8'h01 && mode_supported)
      else $error("mode 38 enables wrong");
   c_back_to_back: cover property (f ##1 f);
   c_unknown: cover property (frame_out_valid && !mode_supported);
   c_dual_pack: cover property (f && m == `MODE_33);
endmodule // lane_mapper_checker
bind jesd_transport_lane_mapper lane_mapper_checker chk (.clk(clk), .rst_b(rst_b),
   .transport_mode_code(transport_mode_code), .frame_in_valid(frame_in_valid),
   .ddc_inphase(ddc_inphase), .overrange_flag_inphase(overrange_flag_inphase),
   .raw_sample(raw_sample), .link_a_lane0(link_a_lane0), .link_a_lane1(link_a_lane1),
   .link_a_lane7(link_a_lane7), .lane_enable_a(lane_enable_a), .lane_enable_b(lane_enable_b),
   .frame_out_valid(frame_out_valid), .mode_supported(mode_supported));
`default_nettype wire

// File: verification/jesd_transport_lane_mapper_test.sv
// Self-checking bench for the lane mapper
`timescale 1ns/1ps
`default_nettype none
`include "lane_mapper_consts.vh"
module jesd_transport_lane_mapper_test;
   logic clk = 1'b0, rst_b = 1'b0, fiv = 1'b0;
   logic [6:0] mode = 7'h00;
   logic [119:0] di = '0, dq = '0;
   logic [7:0] fi = '0, fq = '0;
   logic [14:0] cai = '0, caq = '0, cbi = '0, cbq = '0;
   logic [3:0] cf = '0;
   logic [95:0] raw = '0;
   wire logic [127:0] la, lb, rx_a, rx_b;
   wire logic [7:0] ena, enb, rx_en;
   wire logic fov, sup, rx_valid, rx_sup, rx_gap;
   int n_fail = 0, samples_checked = 0, seed;
   logic [264:0] q[$], e;
   // Link B enables taken off the pins on the cycle the frame appears
   logic [7:0] eb = '0;
   logic [6:0] modes [17] = '{`MODE_24, `MODE_48, `MODE_62, `MODE_65, `MODE_70,
      `MODE_25, `MODE_52, `MODE_26, `MODE_54, `MODE_63, `MODE_27, `MODE_32,
      `MODE_33, `MODE_34, `MODE_35, `MODE_37, `MODE_38};
   always #5 clk = ~clk;
   jesd_transport_lane_mapper dut (.clk(clk), .rst_b(rst_b),
      .transport_mode_code(mode), .frame_in_valid(fiv), .ddc_inphase(di),
      .ddc_quadrature(dq), .overrange_flag_inphase(fi), .overrange_flag_quadrature(fq),
      .chan_a_inphase(cai), .chan_a_quadrature(caq), .chan_b_inphase(cbi),
      .chan_b_quadrature(cbq), .overrange_flag_chan_a_inphase(cf[0]),
      .overrange_flag_chan_a_quadrature(cf[1]), .overrange_flag_chan_b_inphase(cf[2]),
      .overrange_flag_chan_b_quadrature(cf[3]), .raw_sample(raw),
      .link_a_lane0(la[15:0]), .link_a_lane1(la[31:16]), .link_a_lane2(la[47:32]),
      .link_a_lane3(la[63:48]), .link_a_lane4(la[79:64]), .link_a_lane5(la[95:80]),
      .link_a_lane6(la[111:96]), .link_a_lane7(la[127:112]),
      .link_b_lane0(lb[15:0]), .link_b_lane1(lb[31:16]), .link_b_lane2(lb[47:32]),
      .link_b_lane3(lb[63:48]), .link_b_lane4(lb[79:64]), .link_b_lane5(lb[95:80]),
      .link_b_lane6(lb[111:96]), .link_b_lane7(lb[127:112]), .lane_enable_a(ena),
      .lane_enable_b(enb), .frame_out_valid(fov), .mode_supported(sup));
   jesd_lane_receiver rx (.clk(clk), .rst_b(rst_b), .frame_vld(fov), .lanes_a(la),
      .lanes_b(lb), .enable(ena), .supported(sup), .rx_valid(rx_valid), .rx_a(rx_a),
      .rx_b(rx_b), .rx_en(rx_en), .rx_sup(rx_sup), .rx_gap(rx_gap));
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [47:0] pack(input logic [11:0] a, b, c, d);
      pack = {c[3:0], d, b[7:0], c[11:4], a, b[11:8]};
   endfunction
   // Expected frame as {mode known, enables, link B, link A}
   function automatic logic [264:0] expect_frame(input logic [6:0] m);
      logic [127:0] pa, pb;
      logic [11:0] s [8];
      int n;
      logic sh, dd, ok;
      pa = '0; pb = '0; n = 0; sh = 1'b0; dd = 1'b1; ok = 1'b1;
      for (int k = 0; k < 8; k++) s[k] = raw[12*k+:12];
      case (m)
         `MODE_24, `MODE_48, `MODE_62, `MODE_65, `MODE_70: n = 2;
         `MODE_26, `MODE_54, `MODE_63: n = 4;
         `MODE_27: n = 8;
         `MODE_25, `MODE_52: begin n = 8; sh = 1'b1; end
         `MODE_38: n = 1;
         default: dd = 1'b0;
      endcase
      if (dd) for (int k = 0; k < n; k++) begin
         pa[16*k+:16] = {di[15*k+:15], fi[sh ? k/2 : k]};
         pb[16*k+:16] = {dq[15*k+:15], fq[sh ? k/2 : k]};
      end else case (m)
         `MODE_32: begin n = 3;
            pa[47:0] = pack(s[0], s[2], s[4], s[6]);
            pb[47:0] = pack(s[1], s[3], s[5], s[7]); end
         `MODE_33: begin n = 3;
            pa[47:0] = pack(s[0], s[1], s[2], s[3]);
            pb[47:0] = pack(s[4], s[5], s[6], s[7]); end
         `MODE_34: begin n = 2;
            pa[31:0] = {s[2][11:4], 8'h00, s[0][11:4], 8'h00};
            pb[31:0] = {s[3][11:4], 8'h00, s[1][11:4], 8'h00}; end
         `MODE_35: begin n = 2;
            pa[31:0] = {s[1][11:4], 8'h00, s[0][11:4], 8'h00};
            pb[31:0] = {s[5][11:4], 8'h00, s[4][11:4], 8'h00}; end
         `MODE_37: begin n = 2;
            pa[31:0] = {caq, cf[1], cai, cf[0]};
            pb[31:0] = {cbq, cf[3], cbi, cf[2]}; end
         default: ok = 1'b0;
      endcase
      expect_frame = {ok, 8'((1 << n) - 1), pb, pa};
   endfunction
   function automatic logic [127:0] rnd();
      rnd = {$urandom(), $urandom(), $urandom(), $urandom()};
   endfunction
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [127:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic test_done();
      $display("checked %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Inputs change even on idle cycles so holding is really exercised
   task automatic send(input logic [6:0] m, input logic v);
      @(posedge clk);
      di <= rnd(); dq <= rnd(); raw <= rnd(); fi <= 8'($urandom()); fq <= 8'($urandom());
      {cai, caq, cbi, cbq, cf} <= 64'(rnd());
      mode <= m;
      fiv <= v;
      #1 if (v) q.push_back(expect_frame(m));
   endtask
   task automatic drain(input string name);
      @(posedge clk) fiv <= 1'b0;
      for (int i = 0; i < 20 && q.size() != 0; i++) @(posedge clk);
      if (q.size() != 0) begin
         n_fail++;
         $display("unexpected queue: expected 0 seen %0d", q.size());
         test_done();
      end
      $display("test %s finished", name);
   endtask
   always @(negedge clk) if (rx_valid === 1'b1) begin
      if (q.size() == 0) check("frame count", 128'h1, 128'h0);
      else begin
         e = q.pop_front();
         check("link a", rx_a, e[127:0]);
         check("link b", rx_b, e[255:128]);
         check("enables", 128'(rx_en), 128'(e[263:256]));
         check("mode known", 128'(rx_sup), 128'(e[264]));
         check("lane gap", 128'(rx_gap), 128'h0);
         check("enables b", 128'(eb), 128'(e[263:256]));
      end
   end
   always @(negedge clk) if (fov === 1'b1) eb <= enb;
   initial begin
      seed = $urandom(32112);
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      foreach (modes[i]) repeat (2) send(modes[i], 1'b1);
      drain("every mode back to back");
      for (int i = 0; i < 60; i++)
         send((i % 3 == 0) ? 7'($urandom()) : modes[$urandom() % 17], 1'($urandom()));
      drain("gaps and unknown codes");
      send(`MODE_27, 1'b1);
      @(posedge clk) begin rst_b <= 1'b0; fiv <= 1'b0; end
      #1 q.delete();
      @(negedge clk) check("reset enables", 128'(ena), 128'h0);
      @(posedge clk) rst_b <= 1'b1;
      send(`MODE_38, 1'b1);
      send(`MODE_33, 1'b1);
      drain("reset in mid-run");
      test_done();
   end
endmodule // jesd_transport_lane_mapper_test
`default_nettype wire
